// >>> src/usbf_map.svh
`ifndef USBF_MAP_SVH
`define USBF_MAP_SVH
// Overview of operation
// [R1] USB clock is main clock times two/three
// [R2] Software keeps system in full-speed mode
// [R3] Setup write from core beats CPU read
// [R4] Software clears idle FIFOs after connect, reset
// [R5] Suspend/resume interrupt input is falling-edge
// [R6] Packet enable switches bulk-in to other FIFO
// [R7] Writer never exceeds one packet before enable
// [R8] Read only reported size; finish switches FIFO
// [R9] Never read an empty receive FIFO
// [R10] No manual reset during USB traffic
// [R11] Synchronous reset, released after clock stable
// [R12] Software follows fixed reset release order
// [R13] Watchdog reset leaves USB registers unchanged
// [R14] Software writes 03, 80, 00 after reset
// [R15] Control endpoint sources share one interrupt line
// [R16] Every written byte counts toward packet length
// [R17] DMA moves endpoint data bytewise only
// [R18] Module stop two around power-down, then wait
// [R19] Empty IN: NAK, flag set after handshake
// [R20] Flag set again on each further IN token

// ------------------------------------------------------------
// Register byte addresses
// ------------------------------------------------------------
`define USBF_CTRL_OFS 8'h00
`define USBF_STATUS_OFS 8'h04
`define USBF_TRIG_OFS 8'h08
`define USBF_SETUP_DATA_OFS 8'h0C
`define USBF_BULK_IN_DATA_OFS 8'h10
`define USBF_BULK_OUT_DATA_OFS 8'h14
`define USBF_BULK_OUT_SIZE_OFS 8'h18
`define USBF_FLAG_OFS 8'h1C

// ------------------------------------------------------------
// Field positions
// ------------------------------------------------------------
`define USBF_CTRL_CORE_RST 0
`define USBF_CTRL_IF_RST 1
`define USBF_CTRL_CKSEL_LO 4
`define USBF_CTRL_CKSEL_HI 7
`define USBF_CTRL_STOP1 8
`define USBF_CTRL_STOP2 9
`define USBF_TRIG_PACKET_ENABLE_BIT 0
`define USBF_TRIG_READ_FINISH_BIT 1
`define USBF_TRIG_CLR_SETUP 4
`define USBF_TRIG_CLR_IN 5
`define USBF_TRIG_CLR_OUT 6
`define USBF_FLAG_TR 0
`define USBF_FLAG_SETUP 1
`define USBF_FLAG_OUT_RDY 2

// ------------------------------------------------------------
// Reset values and timing
// ------------------------------------------------------------
`define USBF_CTRL_RESET 10'h303
`define USBF_CKSEL_USB 4'h1
`define USBF_STAB_NS 2000
`define USBF_CLK_MHZ 40
`define USBF_STAB_CYC ((`USBF_STAB_NS * `USBF_CLK_MHZ + 999) / 1000)
`endif

// >>> src/usbf_pkg.sv
package usbf_pkg;
	typedef struct packed {
		logic setup_start;
		logic setup_wr;
		logic setup_end;
		logic out_wr;
		logic out_eop;
		logic [7:0] out_data;
		logic in_token;
		logic nak_sent;
		logic in_rd;
		logic in_done;
	} usbf_core_in_t;

	typedef struct packed {
		logic [7:0] in_data;
		logic in_avail;
		logic [6:0] in_len;
		logic nak;
		logic out_busy;
	} usbf_core_out_t;

	typedef enum logic [1:0] {
		CK_STOPPED,
		CK_SETTLING,
		CK_READY
	} usbf_ck_state_t;
endpackage : usbf_pkg

// >>> src/usbf_byte_fifo.sv
`timescale 1ns/100ps
module usbf_byte_fifo #(
	parameter int DEPTH = 64
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clr,
	input wire logic wr_en,
	input wire logic [31:0] wr_data,
	input wire logic [2:0] wr_cnt,
	input wire logic rd_en,
	output logic [7:0] rd_data,
	output logic [$clog2(DEPTH):0] count
);
	localparam int AW = $clog2(DEPTH);

	generate
		if (DEPTH < 4 || (1 << AW) != DEPTH) begin : g_bad
			$error("usbf_byte_fifo: DEPTH must be a power of two >= 4");
		end
	endgenerate

	logic [7:0] mem [DEPTH];
	logic [AW-1:0] wptr_reg;
	logic [AW-1:0] rptr_reg;

	// Up to four bytes land per write so word accesses count bytewise.
	always_ff @(posedge aclk) begin
		if (wr_en) begin
			for (int i = 0; i < 4; i++) begin
				if (i < int'(wr_cnt))
					mem[wptr_reg + AW'(i)] <= wr_data[8*i +: 8];
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || clr) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			count <= '0;
		end else begin
			if (wr_en)
				wptr_reg <= wptr_reg + AW'(wr_cnt);
			if (rd_en)
				rptr_reg <= rptr_reg + 1'b1;
			count <= count + (wr_en ? (AW+1)'(wr_cnt) : '0)
				- (rd_en ? (AW+1)'(1) : '0);
		end
	end

	assign rd_data = mem[rptr_reg];
endmodule : usbf_byte_fifo

// >>> src/usbf_fifo_ctrl.sv
`timescale 1ns/100ps
`include "usbf_map.svh"
module usbf_fifo_ctrl #(
	parameter int MAIN_CLK_MHZ = 24,
	parameter int PKT_MAX = 64,
	parameter int SETUP_BYTES = 8,
	parameter int STAB_CYC = `USBF_STAB_CYC
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wdt_reset,
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire usbf_pkg::usbf_core_in_t core_in,
	output usbf_pkg::usbf_core_out_t core_out,
	output logic [1:0] pll_mult,
	output logic usb_ready
);
	localparam int PW = $clog2(PKT_MAX);
	localparam int SW = $clog2(SETUP_BYTES);

	generate
		if (MAIN_CLK_MHZ != 24 && MAIN_CLK_MHZ != 16) begin : g_bad_clk
			$error("usbf_fifo_ctrl: main clock must be 24 or 16 MHz");
		end
		if (PKT_MAX > 64 || SETUP_BYTES != 8) begin : g_bad_size
			$error("usbf_fifo_ctrl: packet size up to 64, setup 8 bytes");
		end
	endgenerate

	// ------------------------------------------------------------
	// Clock generation and reset release
	// ------------------------------------------------------------
	assign pll_mult = (MAIN_CLK_MHZ == 24) ? 2'h2 : 2'h3; // [R1]

	logic [9:0] ctrl_reg;
	logic [9:0] ctrl_next;
	usbf_pkg::usbf_ck_state_t ck_state_reg;
	logic [$clog2(STAB_CYC+1)-1:0] stab_cnt_reg;
	logic ck_ready;
	logic active;

	assign ck_ready = (ck_state_reg == usbf_pkg::CK_READY);
	// The block only runs once both software resets are lifted.
	assign active = ck_ready && !ctrl_reg[`USBF_CTRL_IF_RST]
		&& !ctrl_reg[`USBF_CTRL_CORE_RST];
	assign usb_ready = active;

	// Settle timer restarts whenever either stop bit or the select drops.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin // [R11]
			ck_state_reg <= usbf_pkg::CK_STOPPED;
			stab_cnt_reg <= '0;
		end else if (ctrl_reg[`USBF_CTRL_STOP1] || ctrl_reg[`USBF_CTRL_STOP2]
			|| ctrl_reg[`USBF_CTRL_CKSEL_HI:`USBF_CTRL_CKSEL_LO]
			!= `USBF_CKSEL_USB) begin
			ck_state_reg <= usbf_pkg::CK_STOPPED;
			stab_cnt_reg <= '0;
		end else begin
			case (ck_state_reg)
			usbf_pkg::CK_STOPPED: begin
				ck_state_reg <= usbf_pkg::CK_SETTLING;
			end
			usbf_pkg::CK_SETTLING: begin
				stab_cnt_reg <= stab_cnt_reg + 1'b1;
				if (stab_cnt_reg == ($bits(stab_cnt_reg))'(STAB_CYC - 1))
					ck_state_reg <= usbf_pkg::CK_READY; // [R11]
			end
			usbf_pkg::CK_READY: begin
				ck_state_reg <= usbf_pkg::CK_READY;
			end
			default: begin
				ck_state_reg <= usbf_pkg::CK_STOPPED;
			end
			endcase
		end
	end

	// ------------------------------------------------------------
	// AXI4-Lite handshake
	// ------------------------------------------------------------
	logic aw_full_reg;
	logic w_full_reg;
	logic [7:0] awaddr_reg;
	logic [31:0] wdata_reg;
	logic [3:0] wstrb_reg;
	logic wr_fire;
	logic rd_fire;

	assign s_axi_awready = !aw_full_reg;
	assign s_axi_wready = !w_full_reg;
	assign s_axi_arready = !s_axi_rvalid;
	assign wr_fire = aw_full_reg && w_full_reg && !s_axi_bvalid;
	assign rd_fire = s_axi_arvalid && s_axi_arready;
	assign s_axi_bresp = 2'h0;
	assign s_axi_rresp = 2'h0;

	// A watchdog reset only aborts bus traffic in flight; registers keep.
	always_ff @(posedge aclk) begin
		if (!aresetn || wdt_reset) begin // [R13]
			aw_full_reg <= 1'b0;
			w_full_reg <= 1'b0;
			s_axi_bvalid <= 1'b0;
		end else begin
			if (s_axi_awvalid && s_axi_awready)
				aw_full_reg <= 1'b1;
			else if (wr_fire)
				aw_full_reg <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
				w_full_reg <= 1'b1;
			else if (wr_fire)
				w_full_reg <= 1'b0;
			if (wr_fire)
				s_axi_bvalid <= 1'b1;
			else if (s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always_ff @(posedge aclk) begin
		if (s_axi_awvalid && s_axi_awready)
			awaddr_reg <= s_axi_awaddr;
		if (s_axi_wvalid && s_axi_wready) begin
			wdata_reg <= s_axi_wdata;
			wstrb_reg <= s_axi_wstrb;
		end
	end

	logic wr_ctrl;
	logic wr_trig;
	logic wr_in;
	logic wr_flag;
	logic rd_setup;
	logic rd_out;

	assign wr_ctrl = wr_fire && awaddr_reg == `USBF_CTRL_OFS;
	assign wr_trig = wr_fire && awaddr_reg == `USBF_TRIG_OFS;
	assign wr_in = wr_fire && awaddr_reg == `USBF_BULK_IN_DATA_OFS;
	assign wr_flag = wr_fire && awaddr_reg == `USBF_FLAG_OFS;
	assign rd_setup = rd_fire && s_axi_araddr == `USBF_SETUP_DATA_OFS;
	assign rd_out = rd_fire && s_axi_araddr == `USBF_BULK_OUT_DATA_OFS;

	// Only the low two bytes carry control fields.
	always_comb begin
		ctrl_next = ctrl_reg;
		if (wstrb_reg[0])
			ctrl_next[7:0] = wdata_reg[7:0];
		if (wstrb_reg[1])
			ctrl_next[9:8] = wdata_reg[9:8];
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) // [R13]
			ctrl_reg <= `USBF_CTRL_RESET;
		else if (wr_ctrl)
			ctrl_reg <= ctrl_next;
	end

	logic packet_enable_bit;
	logic read_finish_bit;
	logic [2:0] fifo_clr;

	assign packet_enable_bit = wr_trig && wstrb_reg[0] && wdata_reg[`USBF_TRIG_PACKET_ENABLE_BIT];
	assign read_finish_bit = wr_trig && wstrb_reg[0] && wdata_reg[`USBF_TRIG_READ_FINISH_BIT];
	assign fifo_clr = (wr_trig && wstrb_reg[0])
		? wdata_reg[`USBF_TRIG_CLR_OUT:`USBF_TRIG_CLR_SETUP] : 3'h0;

	// ------------------------------------------------------------
	// Setup packet FIFO
	// ------------------------------------------------------------
	logic setup_rx_reg;
	logic setup_pop;
	logic [7:0] setup_byte;
	logic [SW:0] setup_cnt;

	// Core writes win: a read that collides with a reception is dropped.
	assign setup_pop = rd_setup && !setup_rx_reg && !core_in.setup_start
		&& !core_in.setup_wr && setup_cnt != '0; // [R3]

	always_ff @(posedge aclk) begin
		if (!aresetn || !active)
			setup_rx_reg <= 1'b0;
		else if (core_in.setup_start)
			setup_rx_reg <= 1'b1;
		else if (core_in.setup_end)
			setup_rx_reg <= 1'b0;
	end

	usbf_byte_fifo #(.DEPTH(SETUP_BYTES)) u_setup (
		.aclk(aclk),
		.aresetn(aresetn),
		.clr(fifo_clr[0] || core_in.setup_start), // [R3]
		.wr_en(active && core_in.setup_wr),
		.wr_data({24'h000000, core_in.out_data}),
		.wr_cnt(3'h1),
		.rd_en(setup_pop),
		.rd_data(setup_byte),
		.count(setup_cnt)
	);

	// ------------------------------------------------------------
	// Bulk-in endpoint, two packet buffers
	// ------------------------------------------------------------
	logic in_cpu_sel_reg;
	logic in_usb_sel_reg;
	logic [1:0] in_full_reg;
	logic [2:0] in_bytes;
	logic [7:0] in_byte [2];
	logic [PW:0] in_cnt [2];

	// Packet length is the sum of enabled lanes, whatever the width.
	always_comb begin
		in_bytes = 3'h0;
		for (int i = 0; i < 4; i++)
			in_bytes = in_bytes + {2'h0, wstrb_reg[i]}; // [R16]
	end

	always_ff @(posedge aclk) begin
		if (!aresetn || fifo_clr[1] || !active) begin
			in_cpu_sel_reg <= 1'b0;
			in_usb_sel_reg <= 1'b0;
			in_full_reg <= 2'h0;
		end else begin
			if (packet_enable_bit && !in_full_reg[in_cpu_sel_reg]) begin
				in_full_reg[in_cpu_sel_reg] <= 1'b1;
				in_cpu_sel_reg <= !in_cpu_sel_reg; // [R6]
			end
			if (core_in.in_done && in_full_reg[in_usb_sel_reg]) begin
				in_full_reg[in_usb_sel_reg] <= 1'b0;
				in_usb_sel_reg <= !in_usb_sel_reg;
			end
		end
	end

	for (genvar b = 0; b < 2; b++) begin : g_in
		usbf_byte_fifo #(.DEPTH(PKT_MAX)) u_buf (
			.aclk(aclk),
			.aresetn(aresetn),
			.clr(fifo_clr[1] || (core_in.in_done && in_usb_sel_reg == b
				&& in_full_reg[b])),
			.wr_en(wr_in && in_cpu_sel_reg == b && !in_full_reg[b]), // [R16]
			.wr_data(wdata_reg),
			.wr_cnt(in_bytes),
			.rd_en(core_in.in_rd && in_usb_sel_reg == b && in_full_reg[b]),
			.rd_data(in_byte[b]),
			.count(in_cnt[b])
		);
	end

	// ------------------------------------------------------------
	// Bulk-out endpoint, two packet buffers
	// ------------------------------------------------------------
	logic out_usb_sel_reg;
	logic out_cpu_sel_reg;
	logic [1:0] out_full_reg;
	logic [7:0] out_byte [2];
	logic [PW:0] out_cnt [2];
	logic [PW:0] rx_size;

	always_ff @(posedge aclk) begin
		if (!aresetn || fifo_clr[2] || !active) begin
			out_usb_sel_reg <= 1'b0;
			out_cpu_sel_reg <= 1'b0;
			out_full_reg <= 2'h0;
		end else begin
			if (core_in.out_eop && !out_full_reg[out_usb_sel_reg]) begin
				out_full_reg[out_usb_sel_reg] <= 1'b1;
				out_usb_sel_reg <= !out_usb_sel_reg;
			end
			if (read_finish_bit && out_full_reg[out_cpu_sel_reg]) begin
				out_full_reg[out_cpu_sel_reg] <= 1'b0;
				out_cpu_sel_reg <= !out_cpu_sel_reg; // [R8]
			end
		end
	end

	// Size shown is the selected buffer's remaining bytes, or zero.
	assign rx_size = out_full_reg[out_cpu_sel_reg]
		? out_cnt[out_cpu_sel_reg] : '0; // [R8]

	for (genvar b = 0; b < 2; b++) begin : g_out
		usbf_byte_fifo #(.DEPTH(PKT_MAX)) u_buf (
			.aclk(aclk),
			.aresetn(aresetn),
			.clr(fifo_clr[2] || (read_finish_bit && out_cpu_sel_reg == b
				&& out_full_reg[b])),
			.wr_en(active && core_in.out_wr && out_usb_sel_reg == b
				&& !out_full_reg[b]),
			.wr_data({24'h000000, core_in.out_data}),
			.wr_cnt(3'h1),
			.rd_en(rd_out && out_cpu_sel_reg == b && out_full_reg[b]),
			.rd_data(out_byte[b]),
			.count(out_cnt[b])
		);
	end

	// ------------------------------------------------------------
	// Core side and flags
	// ------------------------------------------------------------
	logic in_empty;
	logic tr_reg;
	logic setup_flag_reg;

	assign in_empty = !in_full_reg[in_usb_sel_reg];

	always_comb begin
		core_out.in_data = in_byte[in_usb_sel_reg];
		core_out.in_avail = active && !in_empty;
		core_out.in_len = 7'(in_cnt[in_usb_sel_reg]);
		core_out.nak = active && core_in.in_token && in_empty; // [R19]
		core_out.out_busy = out_full_reg[out_usb_sel_reg];
	end

	// Flag follows the handshake, not the token; set beats clear.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tr_reg <= 1'b0;
			setup_flag_reg <= 1'b0;
		end else begin
			if (active && core_in.nak_sent && in_empty)
				tr_reg <= 1'b1; // [R19] [R20]
			else if (wr_flag && wstrb_reg[0] && wdata_reg[`USBF_FLAG_TR])
				tr_reg <= 1'b0;
			if (active && core_in.setup_end)
				setup_flag_reg <= 1'b1;
			else if (wr_flag && wstrb_reg[0] && wdata_reg[`USBF_FLAG_SETUP])
				setup_flag_reg <= 1'b0;
		end
	end

	// ------------------------------------------------------------
	// Read data
	// ------------------------------------------------------------
	always_ff @(posedge aclk) begin
		if (!aresetn || wdt_reset) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h00000000;
		end else if (rd_fire) begin
			s_axi_rvalid <= 1'b1;
			case (s_axi_araddr)
			`USBF_CTRL_OFS:
				s_axi_rdata <= {22'h000000, ctrl_reg};
			`USBF_STATUS_OFS:
				s_axi_rdata <= {28'h0000000, setup_rx_reg,
					|out_full_reg, &in_full_reg, ck_ready};
			`USBF_SETUP_DATA_OFS:
				s_axi_rdata <= {24'h000000,
					setup_pop ? setup_byte : 8'h00}; // [R3]
			`USBF_BULK_OUT_DATA_OFS:
				s_axi_rdata <= {24'h000000,
					out_full_reg[out_cpu_sel_reg]
					? out_byte[out_cpu_sel_reg] : 8'h00};
			`USBF_BULK_OUT_SIZE_OFS:
				s_axi_rdata <= {{(31-PW){1'b0}}, rx_size};
			`USBF_FLAG_OFS:
				s_axi_rdata <= {29'h00000000, |out_full_reg,
					setup_flag_reg, tr_reg};
			default:
				s_axi_rdata <= 32'h00000000;
			endcase
		end else if (s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
endmodule : usbf_fifo_ctrl

// >>> sim/usbf_fifo_ctrl_chk.sv
`timescale 1ns/100ps
module usbf_fifo_ctrl_chk #(
	parameter int MAIN_CLK_MHZ = 24,
	parameter int PKT_MAX = 64
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic wdt_reset,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic [31:0] s_axi_rdata,
	input wire logic [1:0] s_axi_rresp,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [1:0] s_axi_bresp,
	input wire logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire usbf_pkg::usbf_core_in_t core_in,
	input wire usbf_pkg::usbf_core_out_t core_out,
	input wire logic [1:0] pll_mult,
	input wire logic usb_ready
);
	// ----
	// Port relations
	// ----
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	sequence ar_take_s;
		s_axi_arvalid && s_axi_arready;
	endsequence
	sequence r_wait_s;
		s_axi_rvalid && !s_axi_rready;
	endsequence
	pll_mult_a: assert property (
		pll_mult == (MAIN_CLK_MHZ == 24 ? 2'h2 : 2'h3))
		else $error("PLL multiplier does not match main clock");
	// Soft resets and clock settling need several bus writes first.
	ready_late_a: assert property ($rose(aresetn) |-> !usb_ready [*8])
		else $error("usb_ready rose too soon after reset");
	wdt_keep_a: assert property (wdt_reset && usb_ready |=> usb_ready)
		else $error("watchdog reset disturbed the block state");
	nak_empty_a: assert property (
		core_in.in_token && usb_ready && !core_out.in_avail |-> core_out.nak)
		else $error("no NAK for token on empty buffer");
	nak_cause_a: assert property (
		core_out.nak |-> core_in.in_token && !core_out.in_avail)
		else $error("NAK without empty-buffer token");
	// Every byte the core reads from a ready buffer sees a packet length of one to PKT_MAX.
	in_len_a: assert property (core_out.in_avail && core_in.in_rd |->
		core_out.in_len != 7'h00 && core_out.in_len <= PKT_MAX)
		else $error("packet length out of range");
	rd_answer_a: assert property (ar_take_s |=> s_axi_rvalid)
		else $error("read answer late");
	rd_hold_a: assert property (r_wait_s |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped or changed");
	b_drop_a: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid)
		else $error("write answer repeated");
	resp_okay_a: assert property (s_axi_bvalid || s_axi_rvalid |->
		s_axi_bresp == 2'h0 && s_axi_rresp == 2'h0)
		else $error("response code not OKAY");
endmodule : usbf_fifo_ctrl_chk

bind usbf_fifo_ctrl usbf_fifo_ctrl_chk #(.MAIN_CLK_MHZ(MAIN_CLK_MHZ),
	.PKT_MAX(PKT_MAX)) usbf_fifo_ctrl_chk_i (.aclk, .aresetn, .wdt_reset,
	.s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
	.s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid,
	.s_axi_bready, .core_in, .core_out, .pll_mult, .usb_ready);

// >>> sim/usbf_host_model.sv
`timescale 1ns/100ps
module usbf_host_model (
	input wire logic aclk,
	input wire usbf_pkg::usbf_core_out_t core_out,
	output usbf_pkg::usbf_core_in_t core_in
);
	// ----
	// Bit positions of the packed core request
	// ----
	localparam int SETUP_START = 16;
	localparam int SETUP_WR = 15;
	localparam int SETUP_END = 14;
	localparam int OUT_WR = 13;
	localparam int OUT_EOP = 12;
	localparam int IN_TOKEN = 3;
	localparam int NAK_SENT = 2;
	localparam int IN_RD = 1;
	localparam int IN_DONE = 0;
	initial core_in = '0;
	// The idle data byte is inverted so a stale value never looks valid.
	task automatic fire(input int k, input logic [7:0] d, output logic nk);
		usbf_pkg::usbf_core_in_t v;
		v = '0;
		v.out_data = d;
		v[k] = 1'b1;
		@(posedge aclk);
		core_in <= v;
		@(posedge aclk);
		nk = core_out.nak;
		v = '0;
		v.out_data = ~d;
		core_in <= v;
	endtask : fire
	task automatic in_tok(output logic nk);
		logic x;
		fire(IN_TOKEN, 8'h00, nk);
		if (nk)
			fire(NAK_SENT, 8'h00, x);
	endtask : in_tok
	task automatic send_out(input logic [7:0] q[$]);
		logic x;
		foreach (q[i])
			fire(OUT_WR, q[i], x);
		fire(OUT_EOP, 8'h00, x);
	endtask : send_out
	task automatic setup_open;
		logic x;
		fire(SETUP_START, 8'h00, x);
	endtask : setup_open
	task automatic setup_fill(input logic [7:0] q[$]);
		logic x;
		foreach (q[i])
			fire(SETUP_WR, q[i], x);
		fire(SETUP_END, 8'h00, x);
	endtask : setup_fill
	task automatic drain(input int n, input int stall, output logic [7:0] q[$]);
		logic x;
		q = {};
		repeat (n) begin
			repeat (stall) @(posedge aclk);
			#1;
			q.push_back(core_out.in_data);
			fire(IN_RD, 8'h00, x);
		end
		fire(IN_DONE, 8'h00, x);
	endtask : drain
endmodule : usbf_host_model

// >>> sim/test_usbf_fifo_ctrl.sv
`timescale 1ns/100ps
`include "usbf_map.svh"
module test_usbf_fifo_ctrl;
	localparam logic [3:0] STRB [4] = '{4'h1, 4'h3, 4'h7, 4'hF};
	logic aclk = 1'b0;
	logic aresetn = 1'b0;
	logic wdt_reset = 1'b0;
	logic [7:0] s_axi_awaddr = 8'h00;
	logic s_axi_awvalid = 1'b0;
	logic s_axi_awready;
	logic [31:0] s_axi_wdata = 32'h0;
	logic [3:0] s_axi_wstrb = 4'h0;
	logic s_axi_wvalid = 1'b0;
	logic s_axi_wready;
	logic [1:0] s_axi_bresp;
	logic s_axi_bvalid;
	logic s_axi_bready = 1'b1;
	logic [7:0] s_axi_araddr = 8'h00;
	logic s_axi_arvalid = 1'b0;
	logic s_axi_arready;
	logic [31:0] s_axi_rdata;
	logic [1:0] s_axi_rresp;
	logic s_axi_rvalid;
	logic s_axi_rready = 1'b0;
	usbf_pkg::usbf_core_in_t core_in;
	usbf_pkg::usbf_core_out_t core_out;
	logic [1:0] pll_mult;
	logic usb_ready;
	int mismatches = 0;
	int compares = 0;
	always #12.5 aclk = ~aclk;
	usbf_fifo_ctrl #(.MAIN_CLK_MHZ(16), .STAB_CYC(4)) usbf_fifo_ctrl_i (
		.aclk, .aresetn, .wdt_reset, .s_axi_awaddr, .s_axi_awvalid,
		.s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
		.s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
		.s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
		.s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .core_in, .core_out,
		.pll_mult, .usb_ready);
	usbf_host_model usbf_host_model_i (.aclk, .core_out, .core_in);
	// ----
	// Bench tasks
	// ----
	task automatic end_of_test;
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : end_of_test
	task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
		compares++;
		if (got !== exp) begin
			mismatches++;
			$display("FAIL at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : cmp
	task automatic guard(input int n);
		if (n >= 50) begin
			mismatches++;
			end_of_test();
		end
	endtask : guard
	function automatic int nbytes(input logic [3:0] s);
		return $countones(s);
	endfunction : nbytes
	task automatic axw(input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s = 4'hF);
		int n;
		n = 0;
		s_axi_awaddr <= a;
		s_axi_wdata <= d;
		s_axi_wstrb <= s;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid && n < 50);
		guard(n);
	endtask : axw
	// Ready is raised late on purpose so the answer must stand a cycle.
	task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
		int n;
		n = 0;
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid && n < 50);
		guard(n);
		s_axi_rready <= 1'b1;
		@(posedge aclk);
		cmp(s_axi_rdata, exp);
		s_axi_rready <= 1'b0;
	endtask : rdc
	initial begin
		logic [31:0] d;
		logic [3:0] s;
		logic nk;
		logic [7:0] q[$];
		logic [7:0] ex[2][$];
		int n;
		int k;
		int len[2];
		void'($urandom(32'h58714add));
		repeat (4) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`USBF_CTRL_OFS, 32'h303);
		rdc(`USBF_FLAG_OFS, 32'h0);
		cmp(32'(pll_mult), 32'h3);
		axw(`USBF_CTRL_OFS, 32'h203);
		axw(`USBF_CTRL_OFS, 32'h213);
		axw(`USBF_CTRL_OFS, 32'h013);
		n = 0;
		do begin
			@(posedge aclk);
			n++;
		end while (!usb_ready && n < 8 + 4);
		rdc(`USBF_STATUS_OFS, 32'h1);
		axw(`USBF_CTRL_OFS, 32'h011);
		axw(`USBF_CTRL_OFS, 32'h010);
		cmp(32'(usb_ready), 32'h1);
		axw(`USBF_TRIG_OFS, 32'h70);
		for (k = 0; k < 3; k++) begin
			usbf_host_model_i.in_tok(nk);
			cmp(32'(nk), 32'h1);
			rdc(`USBF_FLAG_OFS, 32'h1);
			axw(`USBF_FLAG_OFS, 32'h1);
			rdc(`USBF_FLAG_OFS, 32'h0);
		end
		for (int p = 0; p < 2; p++) begin
			len[p] = 0;
			for (k = 0; k < 3; k++) begin
				d = $urandom;
				s = STRB[$urandom % 4];
				for (n = 0; n < nbytes(s); n++)
					ex[p].push_back(d[8*n+:8]);
				len[p] += nbytes(s);
				axw(`USBF_BULK_IN_DATA_OFS, d, s);
			end
			axw(`USBF_TRIG_OFS, 32'h1);
		end
		rdc(`USBF_STATUS_OFS, 32'h3);
		for (int p = 0; p < 2; p++) begin
			n = 0;
			// Let the buffer swap of the last acknowledge settle first.
			@(posedge aclk);
			while (!core_out.in_avail && n < 50) begin
				@(posedge aclk);
				n++;
			end
			guard(n);
			cmp(32'(core_out.in_len), 32'(len[p]));
			usbf_host_model_i.drain(len[p], p * 3, q);
			foreach (q[i]) cmp(32'(q[i]), 32'(ex[p][i]));
		end
		for (int p = 0; p < 2; p++) begin
			len[p] = 1 + $urandom % 8;
			ex[p] = {};
			repeat (len[p]) ex[p].push_back(8'($urandom));
			usbf_host_model_i.send_out(ex[p]);
		end
		@(posedge aclk);
		cmp(32'(core_out.out_busy), 32'h1);
		for (int p = 0; p < 2; p++) begin
			rdc(`USBF_FLAG_OFS, 32'h4);
			rdc(`USBF_BULK_OUT_SIZE_OFS, 32'(len[p]));
			foreach (ex[p][i]) rdc(`USBF_BULK_OUT_DATA_OFS, 32'(ex[p][i]));
			axw(`USBF_TRIG_OFS, 32'h2);
		end
		rdc(`USBF_FLAG_OFS, 32'h0);
		cmp(32'(core_out.out_busy), 32'h0);
		for (k = 0; k < 2; k++) begin
			q = {};
			repeat (8) q.push_back(8'($urandom));
			usbf_host_model_i.setup_open();
			if (k == 1)
				rdc(`USBF_SETUP_DATA_OFS, 32'h0);
			usbf_host_model_i.setup_fill(q);
			rdc(`USBF_FLAG_OFS, 32'h2);
			for (n = 0; n < 4 + 4 * k; n++) rdc(`USBF_SETUP_DATA_OFS, 32'(q[n]));
		end
		axw(8'h40, 32'hFFFFFFFF);
		rdc(8'h40, 32'h0);
		wdt_reset <= 1'b1;
		repeat (2) @(posedge aclk);
		wdt_reset <= 1'b0;
		@(posedge aclk);
		rdc(`USBF_CTRL_OFS, 32'h010);
		// Power-down parks the clock by stop two; the core stays unreset.
		axw(`USBF_CTRL_OFS, 32'h210);
		@(posedge aclk);
		cmp(32'(usb_ready), 32'h0);
		axw(`USBF_CTRL_OFS, 32'h010);
		n = 0;
		while (!usb_ready && n < 50) begin
			@(posedge aclk);
			n++;
		end
		guard(n);
		rdc(`USBF_STATUS_OFS, 32'h1);
		aresetn <= 1'b0;
		repeat (2) @(posedge aclk);
		aresetn <= 1'b1;
		rdc(`USBF_CTRL_OFS, 32'h303);
		end_of_test();
	end
endmodule : test_usbf_fifo_ctrl
